// >>> bdm_core.sv
`timescale 1ns/1ps
module bdm_core (
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	input  wire logic                        ce,
	input  wire bdm_pkg::bdm_cmd_t           cpu_cmd,
	input  wire logic [15:0]                 cpu_word,
	input  wire logic [15:0]                 cpu_second,
	input  wire logic [bdm_pkg::TGT_W-1:0]   cpu_target,
	input  wire logic [bdm_pkg::BOFS_W-1:0]  cpu_offset,
	input  wire logic                        cpu_access,
	input  wire logic [bdm_pkg::OFS_W-1:0]   cpu_operand,
	input  wire logic [7:0]                  cpu_wdata,
	output logic      [bdm_pkg::PC_W-1:0]    pc_out,
	output logic      [7:0]                  data_rdata,
	output logic      [bdm_pkg::ADDR_W-1:0]  eff_addr,
	output logic                             nop_done,
	output logic                             alu_flag_update,
	output logic                             move_bad,
	input  wire logic [3:0]                  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest
);
	import bdm_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [RAM_BYTES-1:0][7:0] mem;
		logic [BANK_W-1:0]         bank;
		logic [PC_W-1:0]           pc;
		logic [7:0]                rdata;
		logic [ADDR_W-1:0]         eff;
		logic                      nop;
		logic                      flag;
		logic                      bad;
		bdm_bus_t                  bus;
		logic [31:0]               avs_rd;
		logic                      waitreq;
	} bdm_state_t;

	bdm_state_t st_reg;
	bdm_state_t st_next;
	logic       rst_meta_reg;
	logic       rst_sync_reg;

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ------------------------------------------------------------------
	// Address helpers
	// ------------------------------------------------------------------
	function automatic logic is_ram(input logic [ADDR_W-1:0] a);
		is_ram = (a <= RAM_LOW_TOP) ||
			(a >= B15_RAM_LO && a < SPECIAL_LO); // [RL18] [RL19]
	endfunction

	// Bank 15 RAM is packed right after bank 14 RAM so no storage is wasted.
	function automatic logic [11:0] ram_index(input logic [ADDR_W-1:0] a);
		if (a <= RAM_LOW_TOP) begin
			ram_index = a; // [RL8]
		end else begin
			ram_index = a - B15_RAM_LO + NET_REGS_LO; // [RL8]
		end
	endfunction

	function automatic logic [ADDR_W-1:0] form_addr(
		input logic              acc,
		input logic [BANK_W-1:0] bnk,
		input logic [OFS_W-1:0]  op
	);
		if (acc) begin
			form_addr = {bnk, op}; // [RL10] [RL17] [RL7]
		end else if (op < ACCESS_SPLIT) begin
			form_addr = {ACCESS_LO_BANK, op}; // [RL16] [RL21]
		end else begin
			form_addr = {ACCESS_HI_BANK, op}; // [RL16] [RL21]
		end
	endfunction

	function automatic logic [7:0] read_byte(
		input bdm_state_t        s,
		input logic [ADDR_W-1:0] a
	);
		if (is_ram(a)) begin
			read_byte = s.mem[ram_index(a)];
		end else if (a == PC_LOW_ADDR) begin
			read_byte = s.pc[7:0];
		end else if (a == BANK_PTR_ADDR) begin
			read_byte = {4'h0, s.bank}; // [RL11]
		end else begin
			read_byte = 8'h00; // [RL9] [RL13]
		end
	endfunction

	// The pc is kept even by masking bit zero on every load.
	function automatic logic [PC_W-1:0] pc_even(input logic [PC_W-1:0] p);
		pc_even = {p[PC_W-1:1], 1'b0}; // [RL1] [RL2]
	endfunction

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [ADDR_W-1:0] a;
		logic [ADDR_W-1:0] dst;
		logic [PC_W-1:0]   boff;
		logic [7:0]        wb;
		logic              do_wr;
		a       = '0;
		dst     = '0;
		boff    = '0;
		wb      = 8'h00;
		do_wr   = 1'b0;
		st_next = st_reg;
		st_next.nop  = 1'b0;
		st_next.flag = 1'b0;
		st_next.bad  = 1'b0;
		case (cpu_cmd)
			CMD_STEP: begin
				st_next.pc = pc_even(st_reg.pc + PC_STEP); // [RL2]
			end
			CMD_JUMP: begin
				st_next.pc = {cpu_target, 1'b0}; // [RL3]
			end
			CMD_BRANCH: begin
				boff = {{(PC_W-BOFS_W-1){cpu_offset[BOFS_W-1]}},
					cpu_offset, 1'b0};
				st_next.pc = pc_even(st_reg.pc + boff); // [RL4]
			end
			CMD_READ: begin
				a = form_addr(cpu_access, st_reg.bank, cpu_operand);
				st_next.eff   = a;
				st_next.rdata = read_byte(st_reg, a);
				st_next.flag  = 1'b1; // [RL14]
			end
			CMD_WRITE: begin
				a = form_addr(cpu_access, st_reg.bank, cpu_operand);
				st_next.eff  = a;
				wb           = cpu_wdata;
				do_wr        = 1'b1;
				st_next.flag = 1'b1; // [RL14]
			end
			CMD_MOVE: begin
				if (cpu_second[15:12] == SECOND_WORD_TAG) begin // [RL5]
					a   = cpu_word[ADDR_W-1:0];
					dst = cpu_second[ADDR_W-1:0];
					st_next.eff   = dst; // [RL15]
					wb            = read_byte(st_reg, a);
					st_next.rdata = wb;
					do_wr         = 1'b1;
					a             = dst;
					st_next.flag  = 1'b1; // [RL14]
				end else begin
					st_next.bad = 1'b1;
				end
			end
			CMD_LOAD_BANK: begin
				st_next.bank = cpu_word[BANK_W-1:0]; // [RL12]
			end
			CMD_EXEC: begin
				st_next.pc  = pc_even(st_reg.pc + PC_STEP);
				st_next.nop = (cpu_word[15:12] == SECOND_WORD_TAG); // [RL6]
			end
			default: begin
			end
		endcase
		if (do_wr) begin
			if (is_ram(a)) begin
				st_next.mem[ram_index(a)] = wb;
			end else if (a == PC_LOW_ADDR) begin
				st_next.pc = pc_even({st_reg.pc[PC_W-1:8], wb}); // [RL20]
			end else if (a == BANK_PTR_ADDR) begin
				st_next.bank = wb[BANK_W-1:0]; // [RL11]
			end
			// Any other address is dropped silently. [RL13]
		end

		// Register bus, while ce is high: one wait cycle, then a single-cycle answer.
		case (st_reg.bus)
			BUS_IDLE: begin
				st_next.waitreq = 1'b1;
				if (avs_read || avs_write) begin
					st_next.bus     = BUS_ACK;
					st_next.waitreq = 1'b0;
					st_next.avs_rd = 32'h00000000;
					if (avs_read) begin
						case (avs_address)
							REG_BANK:  st_next.avs_rd = {28'h0, st_reg.bank};
							REG_PC:    st_next.avs_rd = {11'h0, st_reg.pc};
							REG_EFF:   st_next.avs_rd = {20'h0, st_reg.eff};
							REG_RDATA: st_next.avs_rd = {24'h0, st_reg.rdata};
							default:   st_next.avs_rd = 32'h00000000;
						endcase
					end
					// The CPU owns the bank pointer when both write at once.
					if (avs_write && avs_address == REG_BANK &&
						avs_byteenable[0] && cpu_cmd != CMD_LOAD_BANK &&
						!do_wr) begin
						st_next.bank = avs_writedata[BANK_W-1:0]; // [RL11]
					end
				end
			end
			BUS_ACK: begin
				st_next.bus     = BUS_IDLE;
				st_next.waitreq = 1'b1;
			end
			default: begin
				st_next.bus     = BUS_IDLE;
				st_next.waitreq = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			st_reg        <= '0;
			st_reg.bank   <= BANK_RESET;
			st_reg.pc     <= PC_RESET;
			st_reg.bus    <= BUS_IDLE;
			st_reg.waitreq <= 1'b1;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign pc_out          = st_reg.pc;
	assign data_rdata      = st_reg.rdata;
	assign eff_addr        = st_reg.eff;
	assign nop_done        = st_reg.nop;
	assign alu_flag_update = st_reg.flag;
	assign move_bad        = st_reg.bad;
	assign avs_readdata    = st_reg.avs_rd;
	assign avs_waitrequest = st_reg.waitreq;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_sync_reg);

	logic go;
	assign go = ce && rst_sync_reg;

	property p_pc_even;
		pc_out[0] == 1'b0;
	endproperty
	a_pc_even: assert property (p_pc_even) else $error("pc odd"); // [RL2]

	property p_step;
		go && cpu_cmd == CMD_STEP |=> pc_out == $past(pc_out) + PC_STEP;
	endproperty
	a_step: assert property (p_step) else $error("step wrong"); // [RL2]

	property p_jump;
		go && cpu_cmd == CMD_JUMP |=> pc_out == {$past(cpu_target), 1'b0};
	endproperty
	a_jump: assert property (p_jump) else $error("jump wrong"); // [RL3]

	property p_branch;
		go && cpu_cmd == CMD_BRANCH |=> pc_out == $past(pc_out) +
			{{(PC_W-BOFS_W-1){$past(cpu_offset[BOFS_W-1])}},
			$past(cpu_offset), 1'b0};
	endproperty
	a_branch: assert property (p_branch) else $error("branch wrong"); // [RL4]

	property p_nop;
		go && cpu_cmd == CMD_EXEC && cpu_word[15:12] == SECOND_WORD_TAG
			|=> nop_done && pc_out == $past(pc_out) + PC_STEP;
	endproperty
	a_nop: assert property (p_nop) else $error("no nop"); // [RL6]

	property p_load_bank;
		go && cpu_cmd == CMD_LOAD_BANK
			|=> st_reg.bank == $past(cpu_word[BANK_W-1:0]);
	endproperty
	a_load_bank: assert property (p_load_bank) else $error("bank load"); // [RL12]

	property p_access_low;
		go && cpu_cmd == CMD_READ && !cpu_access && cpu_operand < 8'h60
			|=> eff_addr == {4'h0, $past(cpu_operand)};
	endproperty
	a_access_low: assert property (p_access_low) else $error("acc lo"); // [RL16]

	property p_access_high;
		go && cpu_cmd == CMD_READ && !cpu_access && cpu_operand >= 8'h60
			|=> eff_addr == {4'hf, $past(cpu_operand)};
	endproperty
	a_access_high: assert property (p_access_high) else $error("acc hi"); // [RL21]

	property p_banked;
		go && cpu_cmd == CMD_READ && cpu_access
			|=> eff_addr == {$past(st_reg.bank), $past(cpu_operand)};
	endproperty
	a_banked: assert property (p_banked) else $error("banked"); // [RL10]

	property p_unimpl_zero;
		go && cpu_cmd == CMD_READ && cpu_access && st_reg.bank == 4'he &&
			cpu_operand[7] |=> data_rdata == 8'h00;
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("nonzero"); // [RL9]

	property p_flags;
		go && (cpu_cmd == CMD_READ || cpu_cmd == CMD_WRITE) |=> alu_flag_update;
	endproperty
	a_flags: assert property (p_flags) else $error("no flags"); // [RL14]

	property p_pcl_write;
		go && cpu_cmd == CMD_WRITE && cpu_access && st_reg.bank == 4'hf &&
			cpu_operand == 8'hf9
			|=> pc_out[7:0] == {$past(cpu_wdata[7:1]), 1'b0};
	endproperty
	a_pcl_write: assert property (p_pcl_write) else $error("pcl"); // [RL20]

	property p_move;
		go && cpu_cmd == CMD_MOVE && cpu_second[15:12] == 4'hf
			|=> eff_addr == $past(cpu_second[11:0]);
	endproperty
	a_move: assert property (p_move) else $error("move dst"); // [RL15]

	property p_move_bad;
		go && cpu_cmd == CMD_MOVE && cpu_second[15:12] != SECOND_WORD_TAG
			|=> move_bad && !alu_flag_update;
	endproperty
	a_move_bad: assert property (p_move_bad) else $error("bad move"); // [RL5]

	property p_bus_answer;
		(avs_read || avs_write) && avs_waitrequest && ce
			|=> !avs_waitrequest ##1 (avs_waitrequest || !$past(ce));
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus late");

	c_nop:   cover property (go && cpu_cmd == CMD_EXEC ##1 nop_done);
	c_pcl:   cover property (go && cpu_cmd == CMD_WRITE && cpu_operand == 8'hf9);
	c_move:  cover property (go && cpu_cmd == CMD_MOVE ##1 alu_flag_update);
	c_avs:   cover property (avs_read ##1 !avs_waitrequest);

endmodule // bdm_core

// >>> bdm_cpu_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Command driver standing in for the CPU
// ------------------------------------------------------------------
module bdm_cpu_model (
	input  wire logic                       core_clk,
	output bdm_pkg::bdm_cmd_t               cpu_cmd,
	output logic [15:0]                     cpu_word,
	output logic [15:0]                     cpu_second,
	output logic [bdm_pkg::TGT_W-1:0]       cpu_target,
	output logic [bdm_pkg::BOFS_W-1:0]      cpu_offset,
	output logic                            cpu_access,
	output logic [bdm_pkg::OFS_W-1:0]       cpu_operand,
	output logic [7:0]                      cpu_wdata
);
	import bdm_pkg::*;
	// Fields are changed only right after an edge, so one command per cycle.
	task automatic drive(input bdm_cmd_t c, input logic [15:0] w, s,
		input logic [19:0] t, input logic [10:0] o, input logic a,
		input logic [7:0] opd, wd);
		@(posedge core_clk);
		cpu_cmd     <= c;
		cpu_word    <= w;
		cpu_second  <= s;
		cpu_target  <= t;
		cpu_offset  <= o;
		cpu_access  <= a;
		cpu_operand <= opd;
		cpu_wdata   <= wd;
	endtask
	initial begin
		cpu_cmd     = CMD_IDLE;
		cpu_word    = 16'h0000;
		cpu_second  = 16'h0000;
		cpu_target  = 20'h00000;
		cpu_offset  = 11'h000;
		cpu_access  = 1'b0;
		cpu_operand = 8'h00;
		cpu_wdata   = 8'h00;
	end
endmodule // bdm_cpu_model

// >>> bdm_pkg.sv
// Summary of operation
// RL1: Program memory is byte addressed; instruction words start on even addresses.
// RL2: Program counter steps two bytes per word; bit zero always reads zero.
// RL3: Absolute call and jump targets are word addresses loaded into pc bits 20:1.
// RL4: Relative branch offsets count single words and are doubled before adding.
// RL5: Second words of two-word instructions carry 1111 on top, 12 literal bits.
// RL6: A word with 1111 on top executed alone acts as a no-operation.
// RL7: Data memory uses 12-bit addresses, sixteen banks of 256 bytes.
// RL8: All sixteen banks exist, giving 3808 bytes of user data memory.
// RL9: Reading any unimplemented data location returns zero.
// RL10: Banked address is bank pointer on top, instruction's eight bits below.
// RL11: Only bank pointer bits 3:0 exist; upper bits read zero, ignore writes.
// RL12: The load bank literal command writes its literal into the bank pointer.
// RL13: Writes to unimplemented space are dropped; reads there return zero.
// RL14: ALU flags update as if the access succeeded, even when unimplemented.
// RL15: Full address move uses complete 12-bit addresses, ignoring bank pointer.
// RL16: Access bit clear maps 00h-5Fh to bank 0, the rest to bank 15 top.
// RL17: Access bit set lets the bank pointer select the operand's bank.
// RL18: Bank 14 is RAM up to E7Fh; E80h-EFFh are network controller registers.
// RL19: Bank 15 is RAM below F60h; F60h-FFFh are special function registers.
// RL20: Banked write to F9h with bank pointer 0Fh lands on the pc low byte.
// RL21: Access bit clear address is bank 0 below 60h else bank 15, plus operand.
package bdm_pkg;

	// ------------------------------------------------------------------
	// Widths and memory map
	// ------------------------------------------------------------------
	localparam int          ADDR_W          = 12;
	localparam int          BANK_W          = 4;
	localparam int          OFS_W           = 8;
	localparam int          PC_W            = 21;
	localparam int          TGT_W           = 20;
	localparam int          BOFS_W          = 11;
	localparam int          RAM_BYTES       = 3808;
	localparam logic [11:0] RAM_LOW_TOP     = 12'he7f;
	localparam logic [11:0] NET_REGS_LO     = 12'he80;
	localparam logic [11:0] NET_REGS_HI     = 12'heff;
	localparam logic [11:0] B15_RAM_LO      = 12'hf00;
	localparam logic [11:0] SPECIAL_LO      = 12'hf60;
	localparam logic [11:0] PC_LOW_ADDR     = 12'hff9;
	localparam logic [11:0] BANK_PTR_ADDR   = 12'hfe0;
	localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;
	localparam logic [3:0]  ACCESS_LO_BANK  = 4'h0;
	localparam logic [3:0]  ACCESS_HI_BANK  = 4'hf;
	localparam logic [3:0]  SECOND_WORD_TAG = 4'hf;
	localparam logic [3:0]  BANK_RESET      = 4'h0;
	localparam logic [20:0] PC_RESET        = 21'h00000;
	localparam logic [20:0] PC_STEP         = 21'h00002;

	// ------------------------------------------------------------------
	// Register bus offsets
	// ------------------------------------------------------------------
	localparam logic [3:0]  REG_BANK        = 4'h0;
	localparam logic [3:0]  REG_PC          = 4'h4;
	localparam logic [3:0]  REG_EFF         = 4'h8;
	localparam logic [3:0]  REG_RDATA       = 4'hc;

	typedef enum logic [3:0] {
		CMD_IDLE,
		CMD_STEP,
		CMD_JUMP,
		CMD_BRANCH,
		CMD_READ,
		CMD_WRITE,
		CMD_MOVE,
		CMD_LOAD_BANK,
		CMD_EXEC
	} bdm_cmd_t;

	typedef enum logic {
		BUS_IDLE,
		BUS_ACK
	} bdm_bus_t;

endpackage

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import bdm_pkg::*;
	logic              core_clk, rst_n, ce, avs_read, avs_write;
	logic [3:0]        avs_address, avs_byteenable;
	logic [31:0]       avs_writedata, avs_readdata, r;
	logic              avs_waitrequest, nop_done, alu_flag_update, move_bad;
	logic [20:0]       pc_out;
	logic [7:0]        data_rdata, cpu_operand, cpu_wdata;
	logic [11:0]       eff_addr;
	bdm_cmd_t          cpu_cmd;
	logic [15:0]       cpu_word, cpu_second;
	logic [19:0]       cpu_target;
	logic [10:0]       cpu_offset;
	logic              cpu_access;
	int                fails, cmp_count;

	bdm_cpu_model cpu (.core_clk, .cpu_cmd, .cpu_word, .cpu_second,
		.cpu_target, .cpu_offset, .cpu_access, .cpu_operand, .cpu_wdata);
	bdm_core dut (.core_clk, .rst_n, .ce, .cpu_cmd, .cpu_word, .cpu_second,
		.cpu_target, .cpu_offset, .cpu_access, .cpu_operand, .cpu_wdata,
		.pc_out, .data_rdata, .eff_addr, .nop_done, .alu_flag_update,
		.move_bad, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest);

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_sim;
		if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Avalon access; request held until waitrequest is sampled low.
	task automatic av(input logic wr, input logic [3:0] ad,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge core_clk);
		avs_address   <= ad;
		avs_writedata <= wd;
		avs_write     <= wr;
		avs_read      <= !wr;
		// No wait length is assumed; only the watchdog ends a stuck access.
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// One command, then idle; outputs settle after the taking edge.
	task automatic op(input bdm_cmd_t c, input logic [15:0] w, s,
		input logic a, input logic [7:0] opd, wd);
		cpu.drive(c, w, s, 20'h0, 11'h0, a, opd, wd);
		cpu.drive(CMD_IDLE, 16'h0, 16'h0, 20'h0, 11'h0, 1'b0, 8'h0, 8'h0);
		#1;
	endtask
	task automatic pc_op(input bdm_cmd_t c, input logic [19:0] t,
		input logic [10:0] o);
		cpu.drive(c, 16'h0, 16'h0, t, o, 1'b0, 8'h0, 8'h0);
		cpu.drive(CMD_IDLE, 16'h0, 16'h0, 20'h0, 11'h0, 1'b0, 8'h0, 8'h0);
		#1;
	endtask
	task automatic bank(input logic [3:0] b);
		op(CMD_LOAD_BANK, {12'h0, b}, 16'h0, 1'b0, 8'h0, 8'h0);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		end_sim;
	end

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		fails = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		ce = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk("pc", 32'h0, pc_out);
		av(1'b0, REG_BANK, 32'h0, r);
		chk("bank", 32'h0, r);
		pc_op(CMD_STEP, 20'h0, 11'h0);
		chk("pc", 32'h2, pc_out);
		pc_op(CMD_JUMP, 20'h00003, 11'h0);
		chk("pc", 32'h6, pc_out);
		pc_op(CMD_BRANCH, 20'h0, 11'h7ff);
		chk("pc", 32'h4, pc_out);
		pc_op(CMD_BRANCH, 20'h0, 11'h003);
		chk("pc", 32'ha, pc_out);
		op(CMD_EXEC, 16'hf456, 16'h0, 1'b0, 8'h0, 8'h0);
		chk("nop", 32'h1, nop_done);
		chk("pc", 32'hc, pc_out);
		op(CMD_EXEC, 16'h0f55, 16'h0, 1'b0, 8'h0, 8'h0);
		chk("nop", 32'h0, nop_done);
		chk("pc bit0", 32'h0, pc_out[0]);
		@(posedge core_clk);
		ce <= 1'b0;
		pc_op(CMD_STEP, 20'h0, 11'h0);
		chk("pc frozen", 32'he, pc_out);
		@(posedge core_clk);
		ce <= 1'b1;
		av(1'b1, REG_PC, 32'hffffffff, r);
		av(1'b0, REG_PC, 32'h0, r);
		chk("pc reg", 32'he, r);
		av(1'b1, REG_BANK, 32'hffffffff, r);
		av(1'b0, REG_BANK, 32'h0, r);
		chk("bank", 32'hf, r);
		bank(4'h5);
		av(1'b0, REG_BANK, 32'h0, r);
		chk("bank", 32'h5, r);
		op(CMD_WRITE, 16'h0, 16'h0, 1'b1, 8'h23, 8'ha5);
		chk("eff", 32'h523, eff_addr);
		chk("flag", 32'h1, alu_flag_update);
		op(CMD_READ, 16'h0, 16'h0, 1'b1, 8'h23, 8'h0);
		chk("rdata", 32'ha5, data_rdata);
		op(CMD_WRITE, 16'h0, 16'h0, 1'b0, 8'h5f, 8'h3c);
		chk("eff", 32'h05f, eff_addr);
		op(CMD_READ, 16'h0, 16'h0, 1'b0, 8'h60, 8'h0);
		chk("eff", 32'hf60, eff_addr);
		chk("rdata", 32'h0, data_rdata);
		bank(4'h0);
		op(CMD_READ, 16'h0, 16'h0, 1'b1, 8'h5f, 8'h0);
		chk("rdata", 32'h3c, data_rdata);
		bank(4'he);
		op(CMD_WRITE, 16'h0, 16'h0, 1'b1, 8'h80, 8'h77);
		chk("flag", 32'h1, alu_flag_update);
		op(CMD_READ, 16'h0, 16'h0, 1'b1, 8'h80, 8'h0);
		chk("rdata", 32'h0, data_rdata);
		op(CMD_WRITE, 16'h0, 16'h0, 1'b1, 8'h7f, 8'h11);
		op(CMD_READ, 16'h0, 16'h0, 1'b1, 8'h7f, 8'h0);
		chk("rdata", 32'h11, data_rdata);
		bank(4'hf);
		op(CMD_WRITE, 16'h0, 16'h0, 1'b1, 8'h5f, 8'h22);
		op(CMD_READ, 16'h0, 16'h0, 1'b1, 8'h5f, 8'h0);
		chk("rdata", 32'h22, data_rdata);
		op(CMD_WRITE, 16'h0, 16'h0, 1'b1, 8'hf9, 8'h41);
		chk("pc low", 32'h40, pc_out[7:0]);
		bank(4'h3);
		op(CMD_MOVE, 16'hc523, 16'hf123, 1'b0, 8'h0, 8'h0);
		chk("rdata", 32'ha5, data_rdata);
		chk("eff", 32'h123, eff_addr);
		bank(4'h1);
		op(CMD_READ, 16'h0, 16'h0, 1'b1, 8'h23, 8'h0);
		chk("rdata", 32'ha5, data_rdata);
		op(CMD_MOVE, 16'hc05f, 16'h0200, 1'b0, 8'h0, 8'h0);
		chk("bad", 32'h1, move_bad);
		chk("flag", 32'h0, alu_flag_update);
		bank(4'h2);
		op(CMD_READ, 16'h0, 16'h0, 1'b1, 8'h00, 8'h0);
		chk("rdata", 32'h0, data_rdata);
		av(1'b0, REG_EFF, 32'h0, r);
		chk("eff reg", 32'h200, r);
		av(1'b0, REG_RDATA, 32'h0, r);
		chk("rdata reg", 32'h0, r);
		end_sim;
	end
endmodule // tb_top
